// ---- debounce_cell.sv ----
// Holds one debounce and transition detection cell for a single input pin.
// Assumes a synchronous pin level and a one-cycle slow tick from the parent.
`timescale 1ns/100ps

module debounce_cell #(
  parameter int CW = 9
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input wire logic raw_in,
  input wire logic det_en_in,
  input wire logic [CW-1:0] target_in,
  output logic level_out,
  output logic change_out
);

  logic primed_q, primed_d;
  logic level_q, level_d;
  logic change_q, change_d;
  logic [CW-1:0] cnt_q, cnt_d;

  // Next state: with detection on, a level that differs must stay for target ticks before it is taken; with it off, it is taken at once.
  always_comb begin
    primed_d = 1'b1;
    level_d = level_q;
    cnt_d = cnt_q;
    change_d = 1'b0;
    if (!primed_q) begin
      level_d = raw_in;
      cnt_d = '0;
    end else if (raw_in == level_q) begin
      cnt_d = '0; // Chatter restarts the wait.
    end else if (!det_en_in) begin
      level_d = raw_in;
      cnt_d = '0;
    end else if (tick_in) begin
      if (cnt_q + 1'b1 >= target_in) begin
        level_d = raw_in;
        cnt_d = '0;
        change_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Registers of the cell.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      primed_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q <= '0;
      change_q <= 1'b0;
    end else begin
      primed_q <= primed_d;
      level_q <= level_d;
      cnt_q <= cnt_d;
      change_q <= change_d;
    end
  end

  assign level_out = level_q;
  assign change_out = change_q;

  // A change is reported only on a slow tick with detection on.
  sequence s_tick_enabled;
    $past(tick_in) && $past(det_en_in);
  endsequence

  a_change_on_tick: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    change_q |-> s_tick_enabled)
    else $error("Change reported without a tick or with detection off.");

  a_change_takes_level: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    change_q |-> (level_q == $past(raw_in)) && (level_q != $past(level_q)))
    else $error("Change reported without a new stable level.");

endmodule

// ---- input_port_change_detect.sv ----
// Holds the scan input port, key port and interrupt pin input logic with its registers.
// Assumes synchronous pin inputs and a single-cycle strobe register master.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "input_port_regs.svh"

module input_port_change_detect #(
  parameter bit INT_RISING = 1'b0,
  parameter input_port_pkg::int_pull_e INT_PULL = input_port_pkg::PULL_UP,
  parameter bit INT_HOLD_USED = 1'b1,
  parameter bit PORT_PULL_UP = 1'b1,
  parameter bit S_HOLD_USED = 1'b1,
  parameter bit K_HOLD_USED = 1'b1,
  parameter int TICK_DIV = `CLK_HZ / `XTAL_HZ,
  parameter int DEB_SHORT_TICKS = (`DEB_SHORT_US * `XTAL_HZ + `US_PER_S - 1) / `US_PER_S,
  parameter int DEB_LONG_TICKS = (`DEB_LONG_US * `XTAL_HZ + `US_PER_S - 1) / `US_PER_S
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic scan_in_bit1_in,
  input wire logic scan_in_bit2_in,
  input wire logic scan_in_bit3_in,
  input wire logic scan_in_bit4_in,
  input wire logic key_io_bit1_in,
  input wire logic key_io_bit2_in,
  input wire logic key_io_bit3_in,
  input wire logic key_io_bit4_in,
  input wire logic ext_int_in,
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  output logic irq_out,
  output logic s_pull_en_out,
  output logic k_pull_en_out,
  output logic port_pull_up_out,
  output logic s_hold_en_out,
  output logic k_hold_en_out,
  output logic int_pull_up_out,
  output logic int_pull_down_out,
  output logic int_hold_en_out
);

  localparam int CW = 9;
  localparam int DW = 12;

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  logic [3:0] scan_raw, key_raw;
  logic [3:0] s_level, k_level, s_chg, k_chg;
  logic started_q, started_d;
  logic [DW-1:0] div_q, div_d;
  logic tick_q, tick_d;
  input_port_pkg::ctrl_s ctrl_q, ctrl_d;
  logic [3:0] s_det_q, s_det_d;
  input_port_pkg::event_s st_q, st_d, mask_q, mask_d, events, clr;
  logic int_prev_q, int_prev_d;
  logic int_edge;
  logic [CW-1:0] deb_target;
  logic [15:0] rd_data_q, rd_data_d;
  logic irq_q, irq_d;
  logic s_pull_q, s_pull_d, k_pull_q, k_pull_d;
  logic s_hold_q, s_hold_d, k_hold_q, k_hold_d;
  logic int_hold_q;
  logic pull_up_q, int_pu_q, int_pd_q;
  logic wr_ctrl, wr_s_det, wr_status, wr_mask;

  assign scan_raw = {scan_in_bit4_in, scan_in_bit3_in, scan_in_bit2_in, scan_in_bit1_in};
  assign key_raw = {key_io_bit4_in, key_io_bit3_in, key_io_bit2_in, key_io_bit1_in};

  // --------------------------------------------------------------------------
  // Release tracking and slow tick divider.
  // --------------------------------------------------------------------------

  // Marks the cycles after reset release and makes the crystal-rate tick.
  always_comb begin
    started_d = 1'b1;
    tick_d = 1'b0;
    div_d = div_q + 1'b1;
    if (div_q == DW'(TICK_DIV - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      started_q <= 1'b0;
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      started_q <= started_d;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // --------------------------------------------------------------------------
  // Debounce cells.
  // --------------------------------------------------------------------------

  // The length select chooses the short or the long exclusion time.
  assign deb_target = ctrl_q.deb_long ? CW'(DEB_LONG_TICKS) : CW'(DEB_SHORT_TICKS);

  // One cell per scan pin, each with its own enable, and per key pin with a shared one.
  for (genvar i = 0; i < 4; i++) begin : g_cells
    debounce_cell #(
      .CW(CW)
    ) u_scan (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .tick_in(tick_q),
      .raw_in(scan_raw[i]),
      .det_en_in(s_det_q[i]),
      .target_in(deb_target),
      .level_out(s_level[i]),
      .change_out(s_chg[i])
    );
    debounce_cell #(
      .CW(CW)
    ) u_key (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .tick_in(tick_q),
      .raw_in(key_raw[i]),
      .det_en_in(ctrl_q.k_det_en),
      .target_in(deb_target),
      .level_out(k_level[i]),
      .change_out(k_chg[i])
    );
  end

  // --------------------------------------------------------------------------
  // Interrupt pin edge detection.
  // --------------------------------------------------------------------------

  // The active edge is a build option; nothing is taken before release.
  always_comb begin
    int_prev_d = ext_int_in;
    if (INT_RISING) begin
      int_edge = started_q && ext_int_in && !int_prev_q;
    end else begin
      int_edge = started_q && !ext_int_in && int_prev_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_prev_q <= 1'b0;
    end else begin
      int_prev_q <= int_prev_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register file, sticky status and interrupt.
  // --------------------------------------------------------------------------
  assign wr_ctrl = wr_in && (addr_in == `REG_CTRL);
  assign wr_s_det = wr_in && (addr_in == `REG_S_DET);
  assign wr_status = wr_in && (addr_in == `REG_STATUS);
  assign wr_mask = wr_in && (addr_in == `REG_MASK);

  // Writes, write-one-to-clear with set winning, and the one-cycle read answer.
  always_comb begin
    ctrl_d = ctrl_q;
    s_det_d = s_det_q;
    mask_d = mask_q;
    events.int_edge = int_edge;
    events.k_chg = k_chg;
    events.s_chg = s_chg;
    clr = wr_status ? wr_data_in[`ST_INT:0] : '0;
    st_d = (st_q & ~clr) | events;
    if (wr_ctrl) begin
      ctrl_d = wr_data_in[`CTRL_DEB_LONG:0];
    end
    if (wr_s_det) begin
      s_det_d = wr_data_in[3:0];
    end
    if (wr_mask) begin
      mask_d = wr_data_in[`ST_INT:0];
    end
    irq_d = |(st_d & mask_d);
    rd_data_d = '0;
    if (rd_in) begin
      unique case (addr_in)
        `REG_CTRL: rd_data_d = {12'h000, ctrl_q};
        `REG_S_DET: rd_data_d = {12'h000, s_det_q};
        `REG_LEVEL: rd_data_d = {8'h00, k_level, s_level};
        `REG_STATUS: rd_data_d = {7'h00, st_q};
        `REG_MASK: rd_data_d = {7'h00, mask_q};
        default: rd_data_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= `CTRL_RESET;
      s_det_q <= `S_DET_RESET;
      st_q <= `STATUS_RESET;
      mask_q <= `MASK_RESET;
      irq_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      s_det_q <= s_det_d;
      st_q <= st_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rd_data_q <= rd_data_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pull and hold controls.
  // --------------------------------------------------------------------------

  // Pulls are on in reset, forced off on the first edge after release, then follow software.
  always_comb begin
    s_pull_d = started_q ? ctrl_d.s_pull_en : 1'b0;
    k_pull_d = started_q ? ctrl_d.k_pull_en : 1'b0;
    s_hold_d = S_HOLD_USED;
    k_hold_d = K_HOLD_USED;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_pull_q <= 1'b1;
      k_pull_q <= 1'b1;
      s_hold_q <= 1'b0;
      k_hold_q <= 1'b0;
      int_hold_q <= INT_HOLD_USED;
      pull_up_q <= PORT_PULL_UP;
      int_pu_q <= (INT_PULL == input_port_pkg::PULL_UP);
      int_pd_q <= (INT_PULL == input_port_pkg::PULL_DOWN);
    end else begin
      s_pull_q <= s_pull_d;
      k_pull_q <= k_pull_d;
      s_hold_q <= s_hold_d;
      k_hold_q <= k_hold_d;
      int_hold_q <= INT_HOLD_USED;
      pull_up_q <= PORT_PULL_UP;
      int_pu_q <= (INT_PULL == input_port_pkg::PULL_UP);
      int_pd_q <= (INT_PULL == input_port_pkg::PULL_DOWN);
    end
  end

  assign rd_data_out = rd_data_q;
  assign irq_out = irq_q;
  assign s_pull_en_out = s_pull_q;
  assign k_pull_en_out = k_pull_q;
  assign port_pull_up_out = pull_up_q;
  assign s_hold_en_out = s_hold_q;
  assign k_hold_en_out = k_hold_q;
  assign int_pull_up_out = int_pu_q;
  assign int_pull_down_out = int_pd_q;
  assign int_hold_en_out = int_hold_q;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------

  // The pin shows its active edge with both samples taken after release.
  sequence s_active_edge;
    started_q && (INT_RISING ? (ext_int_in && !int_prev_q) : (!ext_int_in && int_prev_q));
  endsequence

  a_int_edge_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_active_edge |=> st_q.int_edge)
    else $error("Interrupt pin edge did not set its status bit.");

  a_int_edge_refused: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (!$past(started_q) && !$past(st_q.int_edge)) |-> !st_q.int_edge)
    else $error("Interrupt edge taken before reset release.");

  a_int_hold_kept: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    int_hold_en_out == INT_HOLD_USED)
    else $error("Interrupt pin hold changed.");

  a_int_pull_opt: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(int_pull_up_out && int_pull_down_out) && (int_pull_up_out == (INT_PULL == input_port_pkg::PULL_UP)))
    else $error("Interrupt pin pull does not match the build option.");

  a_pull_release: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(started_q) |-> !s_pull_en_out && !k_pull_en_out && port_pull_up_out == PORT_PULL_UP)
    else $error("Port pulls not off on release.");

  a_pull_follows: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    started_q && wr_ctrl |=> s_pull_en_out == $past(wr_data_in[`CTRL_S_PULL]))
    else $error("Scan port pull did not follow software.");

  a_hold_start: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(started_q) |-> s_hold_en_out == S_HOLD_USED && k_hold_en_out == K_HOLD_USED)
    else $error("Port hold not started at release.");

  a_scan_det_bit: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (s_chg & ~$past(s_det_q)) == 4'h0)
    else $error("Scan change reported on a disabled bit.");

  a_key_det_port: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !$past(ctrl_q.k_det_en) |-> k_chg == 4'h0)
    else $error("Key change reported with detection off.");

  a_irq_gate: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    irq_out == |(st_q & mask_q))
    else $error("Interrupt output does not match masked status.");

endmodule

// ---- input_port_pkg.sv ----
// Holds the types used by the input port block; its debounce cells use none of them.
// Assumes the register constants come from input_port_regs.svh.
package input_port_pkg;

  // Input circuit type of the external interrupt pin.
  typedef enum logic [1:0] {
    PULL_DOWN = 2'b00,
    PULL_UP = 2'b01,
    PULL_OPEN = 2'b10
  } int_pull_e;

  // Software control bits of the port block.
  typedef struct packed {
    logic deb_long;
    logic k_det_en;
    logic k_pull_en;
    logic s_pull_en;
  } ctrl_s;

  // Sticky event bits: interrupt pin edge, key port and scan port changes.
  typedef struct packed {
    logic int_edge;
    logic [3:0] k_chg;
    logic [3:0] s_chg;
  } event_s;

endpackage

// ---- input_port_regs.svh ----
// Holds the register offsets, field positions and timing figures of the input port block.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef INPUT_PORT_REGS_SVH
`define INPUT_PORT_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define REG_CTRL 3'h0
`define REG_S_DET 3'h1
`define REG_LEVEL 3'h2
`define REG_STATUS 3'h3
`define REG_MASK 3'h4

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define CTRL_S_PULL 0
`define CTRL_K_PULL 1
`define CTRL_K_DET 2
`define CTRL_DEB_LONG 3
`define ST_S_LSB 0
`define ST_K_LSB 4
`define ST_INT 8

// ----------------------------------------------------------------------------
// Reset values and timing figures.
// ----------------------------------------------------------------------------
`define CTRL_RESET 4'h0
`define S_DET_RESET 4'h0
`define STATUS_RESET 9'h000
`define MASK_RESET 9'h000
`define CLK_HZ 100000000
`define XTAL_HZ 32768
`define DEB_SHORT_US 1950
`define DEB_LONG_US 7800
`define US_PER_S 1000000

`endif

// ---- switch_bank_model.sv ----
// Holds a behavioural model of the switches, keys and interrupt source wired to the port pins.
// Assumes the bench closes or opens each switch through set_pin, one change per clock edge.
`timescale 1ns/100ps

module switch_bank_model (
  input wire logic mclk_in,
  input wire logic s_pull_en_in,
  input wire logic k_pull_en_in,
  input wire logic pull_up_in,
  input wire logic s_hold_en_in,
  input wire logic k_hold_en_in,
  input wire logic ext_pull_up_in,
  input wire logic ext_pull_down_in,
  input wire logic ext_hold_en_in,
  output logic [3:0] scan_out,
  output logic [3:0] key_out,
  output logic ext_int_out
);
  // ----------------------------------------------------------------------------
  // Pin state: bits 3:0 scan port, 7:4 key port, 8 interrupt pin.
  // ----------------------------------------------------------------------------
  logic [8:0] lvl_q = 9'h1ff;
  logic [8:0] shut_q = 9'h1ff;
  logic [8:0] last_q = 9'h1ff;
  logic flip_q = 1'b0;
  logic [8:0] pon;
  logic [8:0] plv;
  logic [8:0] hon;
  logic [8:0] pin;

  // An open pin follows its pull, else its hold, else it wanders every cycle.
  assign pon = {ext_pull_up_in | ext_pull_down_in, {4{k_pull_en_in}}, {4{s_pull_en_in}}};
  assign plv = {ext_pull_up_in, {8{pull_up_in}}};
  assign hon = {ext_hold_en_in, {4{k_hold_en_in}}, {4{s_hold_en_in}}};
  assign pin = (shut_q & lvl_q) | (~shut_q & ((pon & plv) | (~pon & hon & last_q) | (~pon & ~hon & {9{flip_q}})));
  assign scan_out = pin[3:0];
  assign key_out = pin[7:4];
  assign ext_int_out = pin[8];

  // Remembers the last level for the hold path and makes the wandering pattern.
  always @(posedge mclk_in) begin
    last_q <= pin;
    flip_q <= ~flip_q;
  end

  // Closes or opens one switch just after a rising edge.
  task automatic set_pin(input int idx, input logic closed, input logic level);
    @(posedge mclk_in);
    shut_q[idx] <= closed;
    lvl_q[idx] <= level;
  endtask
endmodule

// ---- tb_input_port_change_detect.sv ----
// Holds the self-checking bench of the input port block with shortened debounce counts.
// Assumes the switch bank model drives every pin and the register port never stalls.
`timescale 1ns/100ps
`include "input_port_regs.svh"

module tb_input_port_change_detect;
  // ----------------------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------------------
  localparam int TDIV = 4;
  localparam int DS = 3;
  localparam int DL = 5;
  typedef struct packed {
    logic [2:0] a;
    logic [15:0] w;
    logic [15:0] r;
    logic [1:0] pulls;
  } row_s;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [15:0] wr_data_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rd_data_out;
  logic irq_out, s_pull_en_out, k_pull_en_out, port_pull_up_out, s_hold_en_out, k_hold_en_out;
  logic int_pull_up_out, int_pull_down_out, int_hold_en_out;
  logic [3:0] scan;
  logic [3:0] key;
  logic ext;
  int fails = 0;
  int n_compared = 0;
  int cnt;
  row_s rows [9];

  // Free-running 100 MHz clock.
  always #5 mclk_in = ~mclk_in;

  input_port_change_detect #(.TICK_DIV(TDIV), .DEB_SHORT_TICKS(DS), .DEB_LONG_TICKS(DL)) u_input_port_change_detect (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .scan_in_bit1_in(scan[0]), .scan_in_bit2_in(scan[1]), .scan_in_bit3_in(scan[2]), .scan_in_bit4_in(scan[3]),
    .key_io_bit1_in(key[0]), .key_io_bit2_in(key[1]), .key_io_bit3_in(key[2]), .key_io_bit4_in(key[3]),
    .ext_int_in(ext), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out), .s_pull_en_out(s_pull_en_out), .k_pull_en_out(k_pull_en_out),
    .port_pull_up_out(port_pull_up_out), .s_hold_en_out(s_hold_en_out), .k_hold_en_out(k_hold_en_out),
    .int_pull_up_out(int_pull_up_out), .int_pull_down_out(int_pull_down_out), .int_hold_en_out(int_hold_en_out));

  switch_bank_model u_switch_bank_model (
    .mclk_in(mclk_in), .s_pull_en_in(s_pull_en_out), .k_pull_en_in(k_pull_en_out),
    .pull_up_in(port_pull_up_out), .s_hold_en_in(s_hold_en_out), .k_hold_en_in(k_hold_en_out),
    .ext_pull_up_in(int_pull_up_out), .ext_pull_down_in(int_pull_down_out), .ext_hold_en_in(int_hold_en_out),
    .scan_out(scan), .key_out(key), .ext_int_out(ext));

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // Reads one register; the data stand one cycle and then return to zero.
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    check("read data", rd_data_out, exp);
    @(negedge mclk_in);
    check("read idle", rd_data_out, 16'h0000);
  endtask

  // Changes one pin and counts cycles until the interrupt output rises.
  task automatic measure(input int idx, input logic lvl);
    u_switch_bank_model.set_pin(idx, 1'b1, lvl);
    cnt = 0;
    do begin
      @(negedge mclk_in);
      cnt++;
    end while (irq_out !== 1'b1 && cnt < 60);
  endtask

  task automatic settle(input logic [15:0] exp);
    repeat (40) @(posedge mclk_in);
    rd(`REG_STATUS, exp);
  endtask

  // Resets the block, toggling the interrupt pin meanwhile, and checks both sides of release.
  task automatic reset_phase();
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    @(negedge mclk_in);
    check("pulls in reset", {k_pull_en_out, s_pull_en_out}, 2'b11);
    check("holds in reset", {k_hold_en_out, s_hold_en_out}, 2'b00);
    check("int hold in reset", int_hold_en_out, 1'b1);
    check("int pull type", {int_pull_up_out, int_pull_down_out}, 2'b10);
    check("port pull dir", port_pull_up_out, 1'b1);
    u_switch_bank_model.set_pin(8, 1'b1, 1'b0);
    u_switch_bank_model.set_pin(8, 1'b1, 1'b1);
    repeat (2) @(posedge mclk_in);
    check("irq in reset", irq_out, 1'b0);
    rst_b_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    check("pulls after reset", {k_pull_en_out, s_pull_en_out}, 2'b00);
    check("holds after reset", {k_hold_en_out, s_hold_en_out}, 2'b11);
    rd(`REG_STATUS, 16'h0000);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    rows[0] = '{`REG_CTRL, 16'hffff, 16'h000f, 2'b11};
    rows[1] = '{`REG_CTRL, 16'h0001, 16'h0001, 2'b01};
    rows[2] = '{`REG_CTRL, 16'h0002, 16'h0002, 2'b10};
    rows[3] = '{`REG_S_DET, 16'hfff5, 16'h0005, 2'b10};
    rows[4] = '{`REG_MASK, 16'hffff, 16'h01ff, 2'b10};
    rows[5] = '{3'h5, 16'hffff, 16'h0000, 2'b10};
    rows[6] = '{3'h7, 16'hffff, 16'h0000, 2'b10};
    rows[7] = '{`REG_LEVEL, 16'h0000, 16'h00ff, 2'b10};
    rows[8] = '{`REG_CTRL, 16'h0000, 16'h0000, 2'b00};
    reset_phase();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
      check("pull enables", {k_pull_en_out, s_pull_en_out}, rows[i].pulls);
    end
    // Short debounce on an enabled scan bit, then clear by writing one.
    measure(0, 1'b0);
    check("short debounce", (cnt >= (DS - 1) * TDIV + 2) && (cnt <= DS * TDIV + 2), 1'b1);
    rd(`REG_STATUS, 16'h0001);
    wr(`REG_STATUS, 16'h0001);
    rd(`REG_STATUS, 16'h0000);
    check("irq after clear", irq_out, 1'b0);
    // Long debounce on the other enabled scan bit.
    wr(`REG_CTRL, 16'h0008);
    measure(2, 1'b0);
    check("long debounce", (cnt >= (DL - 1) * TDIV + 2) && (cnt <= DL * TDIV + 2), 1'b1);
    rd(`REG_STATUS, 16'h0004);
    wr(`REG_STATUS, 16'h0004);
    // A scan bit with detection off follows the pin without a flag.
    u_switch_bank_model.set_pin(1, 1'b1, 1'b0);
    settle(16'h0000);
    rd(`REG_LEVEL, 16'h00f8);
    // A bounce shorter than the debounce time raises nothing.
    u_switch_bank_model.set_pin(0, 1'b1, 1'b1);
    repeat (3) @(posedge mclk_in);
    u_switch_bank_model.set_pin(0, 1'b1, 1'b0);
    settle(16'h0000);
    // Key port detection is switched for the whole port.
    u_switch_bank_model.set_pin(4, 1'b1, 1'b0);
    settle(16'h0000);
    wr(`REG_CTRL, 16'h000c);
    measure(5, 1'b0);
    check("key debounce", (cnt >= (DL - 1) * TDIV + 2) && (cnt <= DL * TDIV + 2), 1'b1);
    rd(`REG_STATUS, 16'h0020);
    wr(`REG_STATUS, 16'h0020);
    // A masked flag stays quiet until its mask bit is set.
    wr(`REG_MASK, 16'h0000);
    u_switch_bank_model.set_pin(6, 1'b1, 1'b0);
    settle(16'h0040);
    check("masked irq", irq_out, 1'b0);
    wr(`REG_MASK, 16'h0040);
    @(negedge mclk_in);
    check("unmasked irq", irq_out, 1'b1);
    wr(`REG_STATUS, 16'h0040);
    @(negedge mclk_in);
    check("cleared irq", irq_out, 1'b0);
    wr(`REG_MASK, 16'h01ff);
    // Falling edge on the interrupt pin flags, the rising edge does not.
    u_switch_bank_model.set_pin(8, 1'b1, 1'b0);
    repeat (4) @(negedge mclk_in);
    check("int edge irq", irq_out, 1'b1);
    rd(`REG_STATUS, 16'h0100);
    wr(`REG_STATUS, 16'h0100);
    u_switch_bank_model.set_pin(8, 1'b1, 1'b1);
    settle(16'h0000);
    // A second reset in mid-run.
    reset_phase();
    rd(`REG_CTRL, 16'h0000);
    tally_and_finish();
  end

  // Cuts a hang short well beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    tally_and_finish();
  end
endmodule
